// ### hw/seg_attr_checker.sv
// Segment descriptor attribute checker with a Wishbone register slave.
// Check answers are registered and appear one cycle after each request.
// Assumes descriptor words, access kind, privilege and offset are valid with
// req_i for one cycle; all inputs are synchronous to clk_i.
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

module seg_attr_checker (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [4:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq_o,
   // Check request from address generation
   input  wire logic        req_i,
   input  wire logic [31:0] desc_lo_i,
   input  wire logic [31:0] desc_hi_i,
   input  wire logic [1:0]  access_kind_i,
   input  wire logic [1:0]  current_privilege_level_i,
   input  wire logic [31:0] offset_i,
   // Check answer
   output logic             done_o,
   output logic             grant_o,
   output logic             fault_o,
   output logic [7:0]       cause_o,
   output logic [31:0]      base_o,
   output logic [31:0]      limit_o,
   output logic             default_32_o,
   output logic             wide_stack_o,
   output logic             system_o,
   output logic [3:0]       sys_type_o,
   output logic             legacy_o,
   // Accessed-flag write-back towards descriptor memory
   output logic             ar_wb_o,
   output logic [7:0]       ar_wb_data_o
);

   // ****************************************************************
   // Field decode
   // ****************************************************************
   logic [7:0]  ar;
   logic        present;
   logic [1:0]  descriptor_privilege_level;
   logic        is_seg;
   logic        is_code;
   logic        expand_direction_flag;
   logic        conforming;
   logic        wr_rd_flag;
   logic        granular;
   logic        size_flag;
   logic [19:0] raw_limit;
   logic        legacy;

   // Access-rights byte and its flags
   assign ar                         = desc_hi_i[seg_check_pkg::HI_AR_HI:seg_check_pkg::HI_AR_LO];
   assign present                    = ar[seg_check_pkg::AR_PRESENT_BIT];
   assign descriptor_privilege_level = ar[seg_check_pkg::AR_PRIV_HI:
                                          seg_check_pkg::AR_PRIV_LO];
   assign is_seg                     = ar[seg_check_pkg::AR_CLASS_BIT];
   assign is_code                    = is_seg & ar[seg_check_pkg::AR_EXEC_BIT];
   assign expand_direction_flag      = ar[seg_check_pkg::AR_DIR_CONF_BIT];
   assign conforming                 = ar[seg_check_pkg::AR_DIR_CONF_BIT];
   assign wr_rd_flag                 = ar[seg_check_pkg::AR_WR_RD_BIT];
   assign granular                   = desc_hi_i[seg_check_pkg::HI_GRAN_BIT];
   assign size_flag                  = desc_hi_i[seg_check_pkg::HI_SIZE_BIT];
   assign raw_limit = {desc_hi_i[seg_check_pkg::HI_LIMIT_HI:seg_check_pkg::HI_LIMIT_LO],
                       desc_lo_i[15:0]};

   // Legacy system format has an all-zero upper half; code and data never qualify
   assign legacy = ~is_seg &
                   (desc_hi_i[seg_check_pkg::HI_UPPER_HI:seg_check_pkg::HI_UPPER_LO]
                    == 16'h0000);

   // ****************************************************************
   // Base and limit
   // ****************************************************************

   // Scale a 20-bit limit by granularity; no dependence on paging
   function automatic logic [31:0] scale_limit(input logic [19:0] lim, input logic g);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (g) begin
         r = {lim, seg_check_pkg::PAGE_FILL};
      end else begin
         r = {12'h000, lim};
      end
      return r;
   endfunction : scale_limit

   // Same-level test, shared by stack loads and non-conforming code fetches
   function automatic logic level_equal(input logic [1:0] cur, input logic [1:0] seg);
      return (cur == seg);
   endfunction : level_equal

   // Reach test: the segment level is numerically not below the current one
   function automatic logic level_reachable(input logic [1:0] cur, input logic [1:0] seg);
      return (seg >= cur);
   endfunction : level_reachable

   logic [31:0] base_full;
   logic [31:0] limit_full;

   // Native descriptors carry 32-bit base and 20-bit limit, legacy 24/16
   // Legacy limits carry no granularity bit and are never scaled
   assign base_full  = legacy ? {8'h00, desc_hi_i[7:0], desc_lo_i[31:16]}
                              : {desc_hi_i[31:24], desc_hi_i[7:0], desc_lo_i[31:16]};
   assign limit_full = legacy ? {16'h0000, desc_lo_i[15:0]}
                              : scale_limit(raw_limit, granular);

   // ****************************************************************
   // Access checks
   // ****************************************************************
   logic        acc_read;
   logic        acc_write;
   logic        acc_exec;
   logic        acc_stack;
   logic [31:0] upper_bound;
   logic        limit_ok;
   logic        priv_ok;
   logic        lvl_eq;
   logic        lvl_reach;
   logic        lvl_conf;
   logic [7:0]  cause;
   logic        fault;

   assign acc_read  = (access_kind_i == seg_check_pkg::ACC_READ);
   assign acc_write = (access_kind_i == seg_check_pkg::ACC_WRITE);
   assign acc_exec  = (access_kind_i == seg_check_pkg::ACC_EXEC);
   assign acc_stack = (access_kind_i == seg_check_pkg::ACC_STACK);

   // Expand-down top depends on the stack width flag
   assign upper_bound = size_flag ? seg_check_pkg::WIDE_STACK_TOP
                                  : seg_check_pkg::NARROW_STACK_TOP;

   // Offset window: expand up at most limit, expand down above limit
   assign limit_ok = (is_code | ~expand_direction_flag)
                     ? (offset_i <= limit_full)
                     : ((offset_i > limit_full) & (offset_i <= upper_bound));

   // Level tests: equal for stack loads and non-conforming fetches, reach for data
   assign lvl_eq    = level_equal(current_privilege_level_i, descriptor_privilege_level);
   assign lvl_reach = level_reachable(current_privilege_level_i, descriptor_privilege_level);
   assign lvl_conf  = (current_privilege_level_i >= descriptor_privilege_level);

   // Conforming code runs from an equal or less privileged level and keeps it
   assign priv_ok = is_code
                    ? (conforming ? lvl_conf : (acc_exec ? lvl_eq : lvl_reach))
                    : (acc_stack ? lvl_eq : lvl_reach);

   // Cause vector; an absent segment reports only that
   // Base, limit and type mean nothing when absent, so nothing else is judged
   always_comb begin
      cause = 8'h00;
      if (!present) begin
         cause[seg_check_pkg::C_NOT_PRESENT] = 1'b1;
      end else if (!is_seg) begin
         cause[seg_check_pkg::C_SYSTEM] = 1'b1;
      end else begin
         if (is_code) begin
            cause[seg_check_pkg::C_WRITE] = acc_write;
            cause[seg_check_pkg::C_READ]  = acc_read & ~wr_rd_flag;
            cause[seg_check_pkg::C_STACK] = acc_stack;
         end else begin
            cause[seg_check_pkg::C_WRITE] = acc_write & ~wr_rd_flag;
            cause[seg_check_pkg::C_EXEC]  = acc_exec;
            cause[seg_check_pkg::C_STACK] = acc_stack & ~wr_rd_flag;
         end
         cause[seg_check_pkg::C_PRIV]  = ~priv_ok;
         cause[seg_check_pkg::C_LIMIT] = ~limit_ok;
      end
   end

   assign fault = (cause != 8'h00);

   // ****************************************************************
   // Answer registers
   // ****************************************************************
   logic        done_reg;
   logic        grant_reg;
   logic        fault_reg;
   logic [7:0]  cause_reg;
   logic [31:0] base_reg;
   logic [31:0] limit_reg;
   logic        d32_reg;
   logic        wstk_reg;
   logic        sys_reg;
   logic [3:0]  sys_type_reg;
   logic        legacy_reg;
   logic        ar_wb_reg;
   logic [7:0]  ar_wb_data_reg;
   logic        aupd_en;
   logic        acc_set;

   // Accessed flag is set when it was clear and update is enabled
   // It is written back even when the access faults: the descriptor was read
   assign acc_set = req_i & aupd_en & ~ar[seg_check_pkg::AR_ACCESSED_BIT];

   // Capture one answer per request
   // Data outputs hold until the next request; the pulses last one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_reg       <= 1'b0;
         grant_reg      <= 1'b0;
         fault_reg      <= 1'b0;
         cause_reg      <= 8'h00;
         base_reg       <= 32'h0000_0000;
         limit_reg      <= 32'h0000_0000;
         d32_reg        <= 1'b0;
         wstk_reg       <= 1'b0;
         sys_reg        <= 1'b0;
         sys_type_reg   <= 4'h0;
         legacy_reg     <= 1'b0;
         ar_wb_reg      <= 1'b0;
         ar_wb_data_reg <= 8'h00;
      end else begin
         done_reg  <= req_i;
         grant_reg <= req_i & ~fault;
         fault_reg <= req_i & fault;
         ar_wb_reg <= acc_set;
         if (req_i) begin
            cause_reg      <= cause;
            base_reg       <= present ? base_full : 32'h0000_0000;
            limit_reg      <= present ? limit_full : 32'h0000_0000;
            d32_reg        <= is_code & size_flag;
            wstk_reg       <= is_seg & ~is_code & size_flag;
            sys_reg        <= ~is_seg;
            sys_type_reg   <= ar[3:0];
            legacy_reg     <= legacy;
            ar_wb_data_reg <= ar | 8'h01;
         end
      end
   end

   assign done_o       = done_reg;
   assign grant_o      = grant_reg;
   assign fault_o      = fault_reg;
   assign cause_o      = cause_reg;
   assign base_o       = base_reg;
   assign limit_o      = limit_reg;
   assign default_32_o = d32_reg;
   assign wide_stack_o = wstk_reg;
   assign system_o     = sys_reg;
   assign sys_type_o   = sys_type_reg;
   assign legacy_o     = legacy_reg;
   assign ar_wb_o      = ar_wb_reg;
   assign ar_wb_data_o = ar_wb_data_reg;

   // ****************************************************************
   // Wishbone register slave
   // ****************************************************************
   // Map: 0x00 control (bit 0 enables the accessed-flag write-back),
   // 0x04 sticky status (bit 0 fault, bit 1 accessed set; a read clears it),
   // 0x08 interrupt mask of the same layout, 0x0c cause of the last fault,
   // 0x10 fault count (a write with sel_i[0] set clears it; a fault in the same cycle wins).
   // Every access is answered one cycle after its strobe is taken; the slave
   // ignores the strobe while ack is high, so a held request is not taken twice.
   logic        ack_reg;
   logic        bus_req;
   logic        wr_stb;
   logic        rd_stb;
   logic [1:0]  ctrl_reg;
   logic [1:0]  status_reg;
   logic [1:0]  status_next;
   logic [1:0]  mask_reg;
   logic [7:0]  last_cause_reg;
   logic [15:0] count_reg;
   logic [31:0] rd_data;
   logic [31:0] dat_reg;
   logic        hit_ctrl;
   logic        hit_status;
   logic        hit_mask;
   logic        hit_cause;
   logic        hit_count;
   logic [1:0]  events;

   // Register select: one compare per mapped offset
   function automatic logic reg_hit(input logic [4:0] adr, input logic [4:0] off);
      return (adr == off);
   endfunction : reg_hit

   // One access per request; answer one cycle after strobe
   assign bus_req    = cyc_i & stb_i & ~ack_reg;
   assign wr_stb     = bus_req & we_i & sel_i[0];
   assign rd_stb     = bus_req & ~we_i;
   assign hit_ctrl   = reg_hit(adr_i, seg_check_pkg::REG_CTRL);
   assign hit_status = reg_hit(adr_i, seg_check_pkg::REG_STATUS);
   assign hit_mask   = reg_hit(adr_i, seg_check_pkg::REG_MASK);
   assign hit_cause  = reg_hit(adr_i, seg_check_pkg::REG_CAUSE);
   assign hit_count  = reg_hit(adr_i, seg_check_pkg::REG_COUNT);
   assign aupd_en    = ctrl_reg[seg_check_pkg::CTRL_AUPD_BIT];

   // Read mux; unmapped addresses read zero
   assign rd_data = hit_ctrl   ? {30'h0, ctrl_reg}   :
                    hit_status ? {30'h0, status_reg} :
                    hit_mask   ? {30'h0, mask_reg}   :
                    hit_cause  ? {24'h0, last_cause_reg} :
                    hit_count  ? {16'h0, count_reg}  : 32'h0000_0000;

   // Events: a fault answer, an accessed-flag write-back
   always_comb begin
      events = 2'h0;
      events[seg_check_pkg::EV_FAULT]    = req_i & fault;
      events[seg_check_pkg::EV_ACCESSED] = acc_set;
   end

   // Sticky status: read clears, a new event in the same cycle wins
   // so that a read can never swallow an event that lands in its own cycle
   assign status_next = ((rd_stb & hit_status) ? 2'h0 : status_reg) | events;

   // Bus handshake and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req;
         dat_reg <= rd_stb ? rd_data : 32'h0000_0000;
      end
   end

   // Control, mask, status and fault bookkeeping
   // A fault in the same cycle as a count clear is still counted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg       <= seg_check_pkg::CTRL_RESET;
         mask_reg       <= seg_check_pkg::MASK_RESET;
         status_reg     <= 2'h0;
         last_cause_reg <= 8'h00;
         count_reg      <= 16'h0000;
      end else begin
         status_reg <= status_next;
         if (wr_stb & hit_ctrl) begin
            ctrl_reg <= dat_i[1:0];
         end
         if (wr_stb & hit_mask) begin
            mask_reg <= dat_i[1:0];
         end
         if (req_i & fault) begin
            last_cause_reg <= cause;
            count_reg      <= count_reg + 16'h0001;
         end else if (wr_stb & hit_count) begin
            count_reg <= 16'h0000;
         end
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;
   assign irq_o = |(status_reg & mask_reg);

endmodule : seg_attr_checker

// ### hw/seg_check_pkg.sv
// Constants for the segment descriptor attribute checker.
// Assumes a 32-bit classic Wishbone register bus and a 100 MHz core clock.
package seg_check_pkg;

   // ****************************************************************
   // Access-rights byte fields
   // ****************************************************************
   localparam int AR_PRESENT_BIT   = 7;
   localparam int AR_PRIV_HI       = 6;
   localparam int AR_PRIV_LO       = 5;
   localparam int AR_CLASS_BIT     = 4;
   localparam int AR_EXEC_BIT      = 3;
   localparam int AR_DIR_CONF_BIT  = 2;
   localparam int AR_WR_RD_BIT     = 1;
   localparam int AR_ACCESSED_BIT  = 0;

   // ****************************************************************
   // Descriptor word layout (low word, high word)
   // ****************************************************************
   localparam int HI_AR_LO         = 8;
   localparam int HI_AR_HI         = 15;
   localparam int HI_LIMIT_LO      = 16;
   localparam int HI_LIMIT_HI      = 19;
   localparam int HI_SIZE_BIT      = 22;
   localparam int HI_GRAN_BIT      = 23;
   localparam int HI_UPPER_LO      = 16;
   localparam int HI_UPPER_HI      = 31;

   // Page size of granular limits is 4 Kbytes: 12 low bits filled with ones
   localparam logic [11:0] PAGE_FILL        = 12'hfff;
   localparam logic [31:0] WIDE_STACK_TOP   = 32'h0fff_ffff;
   localparam logic [31:0] NARROW_STACK_TOP = 32'h0000_ffff;

   // ****************************************************************
   // Access kinds requested by the core
   // ****************************************************************
   localparam logic [1:0] ACC_READ  = 2'h0;
   localparam logic [1:0] ACC_WRITE = 2'h1;
   localparam logic [1:0] ACC_EXEC  = 2'h2;
   localparam logic [1:0] ACC_STACK = 2'h3;

   // ****************************************************************
   // Fault cause bits
   // ****************************************************************
   localparam int CAUSE_W          = 8;
   localparam int C_NOT_PRESENT    = 0;
   localparam int C_SYSTEM         = 1;
   localparam int C_WRITE          = 2;
   localparam int C_READ           = 3;
   localparam int C_EXEC           = 4;
   localparam int C_PRIV           = 5;
   localparam int C_LIMIT          = 6;
   localparam int C_STACK          = 7;

   // ****************************************************************
   // Register map (byte addresses) and reset values
   // ****************************************************************
   localparam logic [4:0]  REG_CTRL      = 5'h00;
   localparam logic [4:0]  REG_STATUS    = 5'h04;
   localparam logic [4:0]  REG_MASK      = 5'h08;
   localparam logic [4:0]  REG_CAUSE     = 5'h0c;
   localparam logic [4:0]  REG_COUNT     = 5'h10;
   localparam int          CTRL_AUPD_BIT = 0;
   localparam logic [1:0]  CTRL_RESET    = 2'h1;
   localparam int          EV_FAULT      = 0;
   localparam int          EV_ACCESSED   = 1;
   localparam logic [1:0]  MASK_RESET    = 2'h0;

endpackage : seg_check_pkg

// ### verification/seg_attr_checker_props.sv
// Concurrent checks on the ports of the segment attribute checker.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module seg_attr_checker_props (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        ack_o,
   input  wire logic        req_i,
   input  wire logic [31:0] desc_hi_i,
   input  wire logic [1:0]  access_kind_i,
   input  wire logic        done_o,
   input  wire logic        grant_o,
   input  wire logic        fault_o,
   input  wire logic [7:0]  cause_o,
   input  wire logic [31:0] limit_o,
   input  wire logic        default_32_o,
   input  wire logic        system_o,
   input  wire logic [7:0]  ar_wb_data_o
);
   // ************************************************************
   // Request shapes
   // ************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_live;
      req_i && desc_hi_i[15] && desc_hi_i[12];
   endsequence
   sequence s_code;
      s_live ##0 desc_hi_i[11];
   endsequence
   sequence s_data;
      s_live ##0 !desc_hi_i[11];
   endsequence
   // ************************************************************
   // Properties
   // ************************************************************
   property p_answer;
      req_i |=> done_o && (grant_o ^ fault_o);
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after request");
   property p_quiet;
      !req_i |=> !done_o && !grant_o && !fault_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_absent;
      req_i && !desc_hi_i[15] |=> fault_o && cause_o == 8'h01;
   endproperty
   a_absent: assert property (p_absent) else $error("absent segment passed");
   property p_code_wr;
      s_code ##0 access_kind_i == 2'h1 |=> fault_o && cause_o[2];
   endproperty
   a_code_wr: assert property (p_code_wr) else $error("code write passed");
   property p_ro_wr;
      s_data ##0 !desc_hi_i[9] && access_kind_i == 2'h1 |=> fault_o && cause_o[2];
   endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("read-only write passed");
   property p_xo_rd;
      s_code ##0 !desc_hi_i[9] && access_kind_i == 2'h0 |=> fault_o && cause_o[3];
   endproperty
   a_xo_rd: assert property (p_xo_rd) else $error("execute-only read passed");
   property p_sys;
      req_i && desc_hi_i[15] && !desc_hi_i[12] |=> system_o && fault_o;
   endproperty
   a_sys: assert property (p_sys) else $error("system class missed");
   property p_acc;
      req_i |=> ar_wb_data_o == ($past(desc_hi_i[15:8]) | 8'h01);
   endproperty
   a_acc: assert property (p_acc) else $error("accessed byte wrong");
   property p_gran;
      s_live ##0 desc_hi_i[23] |=> limit_o[11:0] == 12'hfff;
   endproperty
   a_gran: assert property (p_gran) else $error("page limit not filled");
   property p_size;
      s_code |=> default_32_o == $past(desc_hi_i[22]);
   endproperty
   a_size: assert property (p_size) else $error("default size wrong");
   property p_ack;
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer not one pulse");
endmodule : seg_attr_checker_props

// ### verification/seg_attr_checker_tb.sv
// Self-checking bench for the segment descriptor attribute checker.
// Assumes the package, design and property checker are compiled first.
`timescale 1ns/1ps
module seg_attr_checker_tb;
   localparam logic [1:0] RD = seg_check_pkg::ACC_READ;
   localparam logic [1:0] WR = seg_check_pkg::ACC_WRITE;
   localparam logic [1:0] EX = seg_check_pkg::ACC_EXEC;
   localparam logic [1:0] SK = seg_check_pkg::ACC_STACK;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, req_i = 0;
   logic [4:0]  adr_i = '0;
   logic [3:0]  sel_i = '0;
   logic [1:0]  access_kind_i = '0, current_privilege_level_i = '0;
   logic [31:0] dat_i = '0, desc_lo_i = '0, desc_hi_i = '0, offset_i = '0, rd;
   logic [31:0] dat_o, base_o, limit_o, base_val = 32'ha1b2c3d4;
   logic        ack_o, irq_o, done_o, grant_o, fault_o, default_32_o, wide_stack_o;
   logic        system_o, legacy_o, ar_wb_o, d = 1;
   logic [7:0]  cause_o, ar_wb_data_o;
   logic [3:0]  sys_type_o;
   int          miscompares = 0, checks_done = 0;

   seg_attr_checker seg_attr_checker_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .req_i, .desc_lo_i, .desc_hi_i, .access_kind_i,
      .current_privilege_level_i, .offset_i, .done_o, .grant_o, .fault_o, .cause_o, .base_o,
      .limit_o, .default_32_o, .wide_stack_o, .system_o, .sys_type_o, .legacy_o, .ar_wb_o,
      .ar_wb_data_o);

   // ************************************************************
   // Clock, bus and check tasks
   // ************************************************************
   always #5 clk_i = ~clk_i;

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= v;
      sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      cmp("ack delay", 2, n);
      rd = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
   endtask : wb

   task automatic rchk(input logic [4:0] a, input logic [31:0] e);
      wb(0, a, 0);
      cmp("register", e, rd);
   endtask : rchk

   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle

   // One request pulse; answer is looked at in the cycle after it
   task automatic acc(input logic [7:0] ar, input logic g, input logic [19:0] lim,
      input logic [1:0] k, input logic [1:0] current_privilege_level, input logic [31:0] off,
      input logic ef, input logic [7:0] ec);
      @(posedge clk_i);
      req_i <= 1;
      desc_hi_i <= {base_val[31:24], g, d, 2'b00, lim[19:16], ar, base_val[23:16]};
      desc_lo_i <= {base_val[15:0], lim[15:0]};
      access_kind_i <= k;
      current_privilege_level_i <= current_privilege_level;
      offset_i <= off;
      @(posedge clk_i);
      req_i <= 0;
      #1;
      cmp("done", 1, done_o);
      cmp("fault", ef, fault_o);
      cmp("grant", !ef, grant_o);
      cmp("cause", ec, cause_o);
   endtask : acc

   task automatic give_verdict;
      if (miscompares == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      rchk(5'h00, 32'h1);
      for (int i = 1; i < 6; i++)
         rchk(5'(4 * i), 0);
      wb(1, 5'h0c, 32'hff);
      rchk(5'h0c, 0);
      wb(1, 5'h08, 32'h1);
      rchk(5'h08, 32'h1);
      acc(8'h12, 0, 20'h00fff, RD, 0, 0, 1, 8'h01);
      cmp("cause", 8'h01, cause_o);
      cmp("limit", 0, limit_o);
      settle();
      cmp("irq", 1, irq_o);
      wb(0, 5'h04, 0);
      cmp("status", 1, rd & 1);
      settle();
      cmp("irq", 0, irq_o);
      acc(8'h93, 0, 20'h00fff, RD, 0, 32'hfff, 0, 0);
      acc(8'h93, 0, 20'h00fff, WR, 0, 32'h1000, 1, 8'h40);
      wb(1, 5'h10, 0);
      acc(8'h91, 0, 20'hfffff, WR, 0, 0, 1, 8'h04);
      rchk(5'h0c, 32'h04);
      acc(8'h91, 0, 20'hfffff, SK, 0, 0, 1, 8'h80);
      rchk(5'h10, 2);
      acc(8'h97, 0, 20'h00fff, RD, 0, 32'hfff, 1, 8'h40);
      acc(8'h97, 0, 20'h00fff, RD, 0, 32'h0fffffff, 0, 0);
      cmp("wide", 1, wide_stack_o);
      acc(8'h97, 0, 20'h00fff, RD, 0, 32'h10000000, 1, 8'h40);
      acc(8'h99, 0, 20'hfffff, RD, 0, 0, 1, 8'h08);
      acc(8'h99, 0, 20'hfffff, EX, 0, 0, 0, 0);
      cmp("size", 1, default_32_o);
      acc(8'h9b, 0, 20'hfffff, RD, 0, 0, 0, 0);
      acc(8'h9b, 0, 20'hfffff, WR, 0, 0, 1, 8'h04);
      acc(8'h9b, 0, 20'hfffff, SK, 0, 0, 1, 8'h80);
      acc(8'h93, 0, 20'hfffff, EX, 0, 0, 1, 8'h10);
      acc(8'hdf, 0, 20'hfffff, EX, 3, 0, 0, 0);
      acc(8'hdf, 0, 20'hfffff, EX, 1, 0, 1, 8'h20);
      acc(8'h93, 0, 20'hfffff, RD, 3, 0, 1, 8'h20);
      acc(8'hb3, 0, 20'hfffff, RD, 1, 0, 0, 0);
      acc(8'h93, 1, 20'h00001, RD, 0, 32'h1fff, 0, 0);
      cmp("limit", 32'h1fff, limit_o);
      acc(8'h93, 1, 20'h00001, RD, 0, 32'h2000, 1, 8'h40);
      acc(8'h89, 0, 20'h12345, RD, 0, 0, 1, 8'h02);
      cmp("system", 1, system_o);
      cmp("type", 4'h9, sys_type_o);
      cmp("legacy", 0, legacy_o);
      cmp("base", base_val, base_o);
      cmp("limit", 32'h12345, limit_o);
      d = 0;
      acc(8'h97, 0, 20'h00fff, RD, 0, 32'h10000, 1, 8'h40);
      cmp("wide", 0, wide_stack_o);
      acc(8'h99, 0, 20'hfffff, EX, 0, 0, 0, 0);
      cmp("size", 0, default_32_o);
      base_val = 32'h00b2c3d4;
      acc(8'h82, 0, 20'h0abcd, RD, 0, 0, 1, 8'h02);
      cmp("legacy", 1, legacy_o);
      cmp("base", 32'h00b2c3d4, base_o);
      cmp("limit", 32'h0abcd, limit_o);
      acc(8'h92, 0, 20'hfffff, RD, 0, 0, 0, 0);
      cmp("wb", 1, ar_wb_o);
      cmp("wbdata", 8'h93, ar_wb_data_o);
      wb(1, 5'h00, 0);
      acc(8'h92, 0, 20'hfffff, RD, 0, 0, 0, 0);
      cmp("wb", 0, ar_wb_o);
      wb(1, 5'h08, 0);
      wb(0, 5'h04, 0);
      acc(8'h91, 0, 20'hfffff, WR, 0, 0, 1, 8'h04);
      settle();
      cmp("irq", 0, irq_o);
      wb(1, 5'h08, 32'h1);
      settle();
      cmp("irq", 1, irq_o);
      give_verdict();
   end

   // Watchdog far beyond the roughly 120 cycles the sequence needs
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
endmodule : seg_attr_checker_tb

bind seg_attr_checker seg_attr_checker_props seg_attr_checker_props_inst (.clk_i, .rst_i,
   .cyc_i, .stb_i, .ack_o, .req_i, .desc_hi_i, .access_kind_i, .done_o, .grant_o, .fault_o,
   .cause_o, .limit_o, .default_32_o, .system_o, .ar_wb_data_o);
